// ==== olg_pkg.sv ====
// Constants, carrier types and decode functions for the output path limiter and noise gate.
// Assumes one 25 MHz system clock and 24-bit two's complement audio samples.
`default_nettype none
package olg_pkg;
  localparam int NPATH = 3;
  localparam int DW    = 24;
  localparam int GW    = 9;
  localparam int PAW   = 16;
  localparam int HOLDW = 10;
  localparam int RATEW = 3;

  // Printed offsets are register indices; the byte address is four times the index.
  localparam logic [13:0] HPL_LIMIT_IDX = 14'h0412;
  localparam logic [13:0] HPL_SRC_IDX   = 14'h0413;
  localparam logic [13:0] HPR_LIMIT_IDX = 14'h0416;
  localparam logic [13:0] HPR_SRC_IDX   = 14'h0417;
  localparam logic [13:0] SPK_LIMIT_IDX = 14'h042A;
  localparam logic [13:0] SPK_SRC_IDX   = 14'h042B;
  localparam logic [13:0] GATE_CTRL_IDX = 14'h0458;
  localparam logic [13:0] GATE_STAT_IDX = 14'h0459;
  localparam logic [13:0] RAMP_CTRL_IDX = 14'h045A;

  localparam logic [7:0]  LIMIT_RST    = 8'h81;
  localparam logic [11:0] HPL_SRC_RST  = 12'h001;
  localparam logic [11:0] HPR_SRC_RST  = 12'h002;
  localparam logic [11:0] SPK_SRC_RST  = 12'h040;
  localparam logic [5:0]  GATE_CTRL_RST = 6'h00;
  localparam logic [7:0]  RAMP_CTRL_RST = 8'h00;

  localparam int SRC_HPL_BIT  = 0;
  localparam int SRC_HPR_BIT  = 1;
  localparam int SRC_SPK_BIT  = 6;
  localparam logic [11:0] SRC_VALID = 12'h043;
  localparam int CTRL_ENA_BIT = 0;
  localparam int CTRL_THR_LSB = 1;
  localparam int CTRL_HOLD_LSB = 4;
  localparam int RAMP_VD_LSB  = 0;
  localparam int RAMP_VI_LSB  = 4;
  localparam int STAT_GAIN_LSB = 4;

  localparam logic [GW-1:0] GAIN_UNITY = 9'h100;
  localparam logic [DW-1:0] FS_MAG     = 24'h7FFFFF;

  localparam int CLK_HZ      = 25_000_000;
  localparam int MS_PER_S    = 1000;
  localparam int MS_CYCLES   = CLK_HZ / MS_PER_S;
  localparam int HOLD0_MS    = 30;
  localparam int HOLD1_MS    = 120;
  localparam int HOLD2_MS    = 250;
  localparam int HOLD3_MS    = 500;

  typedef struct packed {
    logic                       valid;
    logic [NPATH-1:0][DW-1:0]   data;
  } olg_stream_t;

  function automatic logic [DW-1:0] olg_mag(input logic [DW-1:0] s);
    olg_mag = s[DW-1] ? DW'(-s) : s;
  endfunction : olg_mag

  // Half-decibel limit levels as Q16 fractions of full scale; 0 dB and above clamp at full scale.
  function automatic logic [DW-1:0] olg_limit_mag(input logic [7:0] code);
    logic [16:0]   frac;
    logic [DW+16:0] prod;
    case (code)
      8'h74:   frac = 17'h0804E;
      8'h75:   frac = 17'h087E8;
      8'h76:   frac = 17'h08FF6;
      8'h77:   frac = 17'h0987D;
      8'h78:   frac = 17'h0A186;
      8'h79:   frac = 17'h0AB19;
      8'h7A:   frac = 17'h0B53C;
      8'h7B:   frac = 17'h0BFF9;
      8'h7C:   frac = 17'h0CB59;
      8'h7D:   frac = 17'h0D766;
      8'h7E:   frac = 17'h0E429;
      8'h7F:   frac = 17'h0F1AE;
      default: frac = 17'h10000;
    endcase
    prod = {17'h00000, FS_MAG} * {{DW{1'b0}}, frac};
    olg_limit_mag = prod[DW+15:16];
  endfunction : olg_limit_mag

  // Threshold amplitudes in units of full scale divided by two to the 24th.
  function automatic logic [15:0] olg_thr_q24(input logic [2:0] code);
    case (code)
      3'h0:    olg_thr_q24 = 16'h4189;
      3'h1:    olg_thr_q24 = 16'h20D9;
      3'h2:    olg_thr_q24 = 16'h1076;
      3'h3:    olg_thr_q24 = 16'h0840;
      3'h4:    olg_thr_q24 = 16'h0423;
      3'h5:    olg_thr_q24 = 16'h0213;
      3'h6:    olg_thr_q24 = 16'h010A;
      default: olg_thr_q24 = 16'h0085;
    endcase
  endfunction : olg_thr_q24

  function automatic logic [HOLDW-1:0] olg_hold_ms(input logic [1:0] code);
    case (code)
      2'h0:    olg_hold_ms = HOLDW'(HOLD0_MS);
      2'h1:    olg_hold_ms = HOLDW'(HOLD1_MS);
      2'h2:    olg_hold_ms = HOLDW'(HOLD2_MS);
      default: olg_hold_ms = HOLDW'(HOLD3_MS);
    endcase
  endfunction : olg_hold_ms
endpackage : olg_pkg
`default_nettype wire

// ==== olg_limiter.sv ====
// One output path's digital clipper, registered once.
// Assumes samples arrive with a one-cycle valid strobe at the audio sample rate.
`timescale 1ns/10ps
`default_nettype none
module olg_limiter
  import olg_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          in_valid,
  input  wire logic [DW-1:0] in_sample,
  input  wire logic [7:0]    limit_code,
  output logic               out_valid,
  output logic [DW-1:0]      out_sample
);
  typedef struct packed {
    logic          valid;
    logic [DW-1:0] smp;
  } olg_lim_state_t;

  olg_lim_state_t st_q;
  olg_lim_state_t st_d;
  logic [DW-1:0]  lim;

  always_comb begin
    st_d  = st_q;
    lim   = olg_limit_mag(limit_code);
    st_d.valid = in_valid;
    if (in_valid) begin
      if ($signed(in_sample) > $signed(lim)) begin
        st_d.smp = lim; // [RULE_01] [RULE_02] [RULE_04]
      end else if ($signed(in_sample) < $signed(DW'(-lim))) begin
        st_d.smp = DW'(-lim); // [RULE_01]
      end else begin
        st_d.smp = in_sample;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign out_valid  = st_q.valid;
  assign out_sample = st_q.smp;

  property p_clip_bound;
    @(posedge pclk) disable iff (!presetn)
      out_valid |-> olg_mag(out_sample) <= olg_limit_mag($past(limit_code));
  endproperty
  a_clip_bound: assert property (p_clip_bound) else $error("clipped sample above limit"); // [RULE_01]

  property p_pass_small;
    @(posedge pclk) disable iff (!presetn)
      (in_valid && olg_mag(in_sample) < olg_limit_mag(limit_code))
        |=> out_valid && out_sample == $past(in_sample);
  endproperty
  a_pass_small: assert property (p_pass_small) else $error("sample under limit altered"); // [RULE_04]
endmodule : olg_limiter
`default_nettype wire

// ==== olg_gate_timer.sv ====
// Hold timer and gate state for one output path.
// Assumes a one-cycle millisecond tick and a per-sample quiet flag from the top level.
`timescale 1ns/10ps
`default_nettype none
module olg_gate_timer
  import olg_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       enable,
  input  wire logic       sample_valid,
  input  wire logic       quiet,
  input  wire logic       ms_tick,
  input  wire logic [1:0] hold_code,
  output logic            gate_active
);
  typedef enum logic [1:0] {
    GT_IDLE  = 2'b00,
    GT_COUNT = 2'b01,
    GT_MUTE  = 2'b10
  } olg_gate_st_t;

  typedef struct packed {
    olg_gate_st_t     st;
    logic [HOLDW-1:0] cnt;
  } olg_gate_state_t;

  olg_gate_state_t s_q;
  olg_gate_state_t s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      GT_IDLE: begin
        s_d.cnt = '0;
        if (enable && sample_valid && quiet) begin
          s_d.st = GT_COUNT; // [RULE_06]
        end
      end
      GT_COUNT: begin
        if (!enable || (sample_valid && !quiet)) begin
          s_d.st  = GT_IDLE; // [RULE_17]
          s_d.cnt = '0;
        end else if (ms_tick) begin
          // The gate closes on the tick after the count reaches the hold figure, so only after more than that many ms.
          if (s_q.cnt == olg_hold_ms(hold_code)) begin
            s_d.st = GT_MUTE; // [RULE_13] [RULE_14]
          end else begin
            s_d.cnt = HOLDW'(s_q.cnt + 1'b1);
          end
        end
      end
      GT_MUTE: begin
        if (!enable || (sample_valid && !quiet)) begin
          s_d.st  = GT_IDLE; // [RULE_07] [RULE_17]
          s_d.cnt = '0;
        end
      end
      default: begin
        s_d.st  = GT_IDLE;
        s_d.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{st: GT_IDLE, cnt: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign gate_active = (s_q.st == GT_MUTE);

  property p_release;
    @(posedge pclk) disable iff (!presetn)
      (sample_valid && !quiet) |=> !gate_active;
  endproperty
  a_release: assert property (p_release) else $error("gate held with loud source"); // [RULE_17]

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      !enable |=> !gate_active;
  endproperty
  a_disabled: assert property (p_disabled) else $error("gate active while disabled"); // [RULE_07]

  property p_hold_done;
    @(posedge pclk) disable iff (!presetn)
      $rose(gate_active) |-> $past(s_q.cnt) == olg_hold_ms($past(hold_code)) && $past(ms_tick);
  endproperty
  a_hold_done: assert property (p_hold_done) else $error("gate before hold time"); // [RULE_13]
endmodule : olg_gate_timer
`default_nettype wire

// ==== olg_top.sv ====
// APB-programmed limiter and noise gate for the three output paths.
// Assumes a 25 MHz pclk, an APB master, and one sample per path per valid strobe.
// Overview of operation
// [RULE_01] Any sample beyond the path limit is clipped and held at that limit level.
// [RULE_02] Clipping is done on the digital stream, before the path's converter.
// [RULE_03] Software is expected to keep limits at full scale to avoid clipping later on.
// [RULE_04] The 8-bit limit code is read in half-decibel steps from -6 dB at 74h to +6 dB at 8Ch; codes 80h to 8Ch all clip at full scale (0 dB) here.
// [RULE_05] Software never writes limit codes below 74h or above 8Ch.
// [RULE_06] An enabled gate whose sources are below threshold mutes its path.
// [RULE_07] One global enable bit turns the whole gate function on and off.
// [RULE_08] With several sources selected, a path mutes only while all of them are quiet.
// [RULE_09] Source mask bit 0 is headphone left, bit 1 headphone right, bit 6 speaker.
// [RULE_10] The shared 3-bit threshold runs from -60 dB at code 0 to -102 dB at code 7.
// [RULE_11] The threshold is compared with the level after the limiter, free of volume.
// [RULE_12] Each path's gate decides on its own sources and content.
// [RULE_13] A gate closes only after the quiet condition lasts longer than the hold time.
// [RULE_14] Hold codes 0 to 3 give 30, 120, 250 and 500 ms.
// [RULE_15] A closing gate ramps the path down at the decrease rate.
// [RULE_16] An opening gate ramps the path back up at the increase rate.
// [RULE_17] A source going loud restarts the hold timer and opens the gate.
`timescale 1ns/10ps
`default_nettype none
module olg_top
  import olg_pkg::*;
#(
  parameter int CYCLES_PER_MS = MS_CYCLES
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [PAW-1:0]   paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire olg_stream_t      in_stream,
  output olg_stream_t           out_stream
);
  localparam int TW = $clog2(CYCLES_PER_MS + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(CYCLES_PER_MS - 1);

  typedef struct packed {
    logic [NPATH-1:0][7:0]    limit;
    logic [NPATH-1:0][11:0]   mask;
    logic [5:0]               ctrl;
    logic [7:0]               ramp;
    logic [NPATH-1:0][GW-1:0] gain;
    logic [NPATH-1:0][RATEW-1:0] rcnt;
    logic [TW-1:0]            tcnt;
    logic                     tick;
    logic [31:0]              rdata;
    logic                     ready;
    logic                     err;
    olg_stream_t              out;
  } olg_top_state_t;

  olg_top_state_t r_q;
  olg_top_state_t r_d;

  logic [NPATH-1:0]         lim_valid;
  logic [NPATH-1:0][DW-1:0] lim_smp;
  logic [NPATH-1:0]         below;
  logic [NPATH-1:0]         quiet;
  logic [NPATH-1:0]         active;
  logic [DW:0]              thr_cmp;

  // Pick the three meaningful source bits out of a 12-bit mask, in path order.
  function automatic logic [NPATH-1:0] olg_sel(input logic [11:0] m);
    olg_sel = {m[SRC_SPK_BIT], m[SRC_HPR_BIT], m[SRC_HPL_BIT]};
  endfunction : olg_sel

  function automatic logic olg_known(input logic [13:0] idx);
    olg_known = (idx == HPL_LIMIT_IDX) || (idx == HPL_SRC_IDX) ||
                (idx == HPR_LIMIT_IDX) || (idx == HPR_SRC_IDX) ||
                (idx == SPK_LIMIT_IDX) || (idx == SPK_SRC_IDX) ||
                (idx == GATE_CTRL_IDX) || (idx == GATE_STAT_IDX) ||
                (idx == RAMP_CTRL_IDX);
  endfunction : olg_known

  assign thr_cmp = (DW+1)'(olg_thr_q24(r_q.ctrl[CTRL_THR_LSB +: 3]));

  genvar gp;
  generate
    for (gp = 0; gp < NPATH; gp++) begin : g_path
      olg_limiter u_lim (
        .pclk       (pclk),
        .presetn    (presetn),
        .in_valid   (in_stream.valid),
        .in_sample  (in_stream.data[gp]),
        .limit_code (r_q.limit[gp]),
        .out_valid  (lim_valid[gp]),
        .out_sample (lim_smp[gp])
      );

      // The limited stream ignores volume, so it stands for the level at the pin.
      assign below[gp] = {olg_mag(lim_smp[gp]), 1'b0} < thr_cmp; // [RULE_10] [RULE_11]

      // An empty mask never closes the gate; all selected sources must be quiet.
      assign quiet[gp] = (|olg_sel(r_q.mask[gp])) &&
                         (&(below | ~olg_sel(r_q.mask[gp]))); // [RULE_08] [RULE_09] [RULE_12]

      olg_gate_timer u_gate (
        .pclk         (pclk),
        .presetn      (presetn),
        .enable       (r_q.ctrl[CTRL_ENA_BIT]),
        .sample_valid (lim_valid[gp]),
        .quiet        (quiet[gp]),
        .ms_tick      (r_q.tick),
        .hold_code    (r_q.ctrl[CTRL_HOLD_LSB +: 2]),
        .gate_active  (active[gp])
      ); // [RULE_06] [RULE_07] [RULE_13]

      property p_ramp_down;
        @(posedge pclk) disable iff (!presetn)
          active[gp] |=> r_q.gain[gp] <= $past(r_q.gain[gp]);
      endproperty
      a_ramp_down: assert property (p_ramp_down) else $error("gain rose while gated"); // [RULE_15]

      property p_ramp_up;
        @(posedge pclk) disable iff (!presetn)
          !active[gp] |=> r_q.gain[gp] >= $past(r_q.gain[gp]);
      endproperty
      a_ramp_up: assert property (p_ramp_up) else $error("gain fell while open"); // [RULE_16]

      property p_step_one;
        @(posedge pclk) disable iff (!presetn)
          $changed(r_q.gain[gp]) |-> $past(lim_valid[gp]) &&
            (r_q.gain[gp] - $past(r_q.gain[gp]) == 9'h001 ||
             $past(r_q.gain[gp]) - r_q.gain[gp] == 9'h001);
      endproperty
      a_step_one: assert property (p_step_one) else $error("gain jumped"); // [RULE_15] [RULE_16]
    end
  endgenerate

  always_comb begin
    logic [13:0]         idx;
    logic                acc;
    logic [RATEW-1:0]    rate;
    logic [DW+GW:0]      prod;
    idx  = paddr[PAW-1:2];
    acc  = psel && penable && r_q.ready;
    rate = '0;
    prod = '0;
    r_d  = r_q;

    // Millisecond tick for the hold timers.
    r_d.tick = 1'b0;
    if (r_q.tcnt == TICK_LAST) begin
      r_d.tcnt = '0;
      r_d.tick = 1'b1;
    end else begin
      r_d.tcnt = TW'(r_q.tcnt + 1'b1);
    end

    // One wait state: ready rises in the second access cycle and drops after.
    r_d.ready = psel && penable && !r_q.ready;
    r_d.err   = psel && penable && !r_q.ready && !olg_known(idx);
    if (psel && penable && !r_q.ready) begin
      case (idx)
        HPL_LIMIT_IDX: r_d.rdata = {24'h000000, r_q.limit[0]};
        HPR_LIMIT_IDX: r_d.rdata = {24'h000000, r_q.limit[1]};
        SPK_LIMIT_IDX: r_d.rdata = {24'h000000, r_q.limit[2]};
        HPL_SRC_IDX:   r_d.rdata = {20'h00000, r_q.mask[0]};
        HPR_SRC_IDX:   r_d.rdata = {20'h00000, r_q.mask[1]};
        SPK_SRC_IDX:   r_d.rdata = {20'h00000, r_q.mask[2]};
        GATE_CTRL_IDX: r_d.rdata = {26'h0000000, r_q.ctrl};
        RAMP_CTRL_IDX: r_d.rdata = {24'h000000, r_q.ramp};
        GATE_STAT_IDX: r_d.rdata = {1'b0, r_q.gain, 1'b0, active};
        default:       r_d.rdata = 32'h00000000;
      endcase
    end
    if (acc && pwrite) begin
      case (idx)
        HPL_LIMIT_IDX: r_d.limit[0] = pwdata[7:0]; // [RULE_05]
        HPR_LIMIT_IDX: r_d.limit[1] = pwdata[7:0];
        SPK_LIMIT_IDX: r_d.limit[2] = pwdata[7:0];
        HPL_SRC_IDX:   r_d.mask[0]  = pwdata[11:0] & SRC_VALID; // [RULE_09]
        HPR_SRC_IDX:   r_d.mask[1]  = pwdata[11:0] & SRC_VALID;
        SPK_SRC_IDX:   r_d.mask[2]  = pwdata[11:0] & SRC_VALID;
        GATE_CTRL_IDX: r_d.ctrl     = pwdata[5:0]; // [RULE_07] [RULE_10] [RULE_14]
        RAMP_CTRL_IDX: r_d.ramp     = {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
        default:       r_d.ramp     = r_q.ramp;
      endcase
    end

    // Gain ramps one step every (rate + 1) samples toward zero or unity.
    r_d.out.valid = lim_valid[0];
    for (int p = 0; p < NPATH; p++) begin
      rate = active[p] ? r_q.ramp[RAMP_VD_LSB +: RATEW] : r_q.ramp[RAMP_VI_LSB +: RATEW];
      if (lim_valid[p]) begin
        prod = $signed(lim_smp[p]) * $signed({1'b0, r_q.gain[p]});
        r_d.out.data[p] = prod[DW+7:8];
        if ((active[p] && r_q.gain[p] == '0) || (!active[p] && r_q.gain[p] == GAIN_UNITY)) begin
          r_d.rcnt[p] = '0;
        end else if (r_q.rcnt[p] == rate) begin
          r_d.rcnt[p] = '0;
          if (active[p]) begin
            r_d.gain[p] = GW'(r_q.gain[p] - 1'b1); // [RULE_15]
          end else begin
            r_d.gain[p] = GW'(r_q.gain[p] + 1'b1); // [RULE_16]
          end
        end else begin
          r_d.rcnt[p] = RATEW'(r_q.rcnt[p] + 1'b1);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q       <= '0;
      r_q.limit <= {LIMIT_RST, LIMIT_RST, LIMIT_RST};
      r_q.mask  <= {SPK_SRC_RST, HPR_SRC_RST, HPL_SRC_RST};
      r_q.ctrl  <= GATE_CTRL_RST;
      r_q.ramp  <= RAMP_CTRL_RST;
      r_q.gain  <= {GAIN_UNITY, GAIN_UNITY, GAIN_UNITY};
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata     = r_q.rdata;
  assign pready     = r_q.ready;
  assign pslverr    = r_q.err;
  assign out_stream = r_q.out;

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("no ready after one wait state");

  property p_muted_zero;
    @(posedge pclk) disable iff (!presetn)
      (lim_valid[0] && r_q.gain[0] == '0) |=> out_stream.data[0] == '0;
  endproperty
  a_muted_zero: assert property (p_muted_zero) else $error("muted path not silent"); // [RULE_06]
endmodule : olg_top
`default_nettype wire

// ==== olg_mixer_model.sv ====
// Upstream mixing core model that sends one three-lane frame per request strobe.
// Assumes the request and frame are changed just after a rising edge of pclk.
`timescale 1ns/10ps
`default_nettype none
module olg_mixer_model
  import olg_pkg::*;
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     req,
  input  wire logic [NPATH-1:0][DW-1:0] frame,
  output var  olg_stream_t              stream
);
  // Between frames the lanes toggle, so a late sample in the design shows up as junk.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stream <= '0;
    end else begin
      stream.valid <= req;
      stream.data  <= req ? frame : ~stream.data;
    end
  end
endmodule : olg_mixer_model
`default_nettype wire

// ==== tb_output_path_limiter_noise_gate.sv ====
// Self-checking bench for the output path limiter and noise gate.
// Assumes olg_pkg, olg_top and olg_mixer_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_output_path_limiter_noise_gate;
  import olg_pkg::*;
  localparam int            CPM   = 4;
  localparam logic [DW-1:0] LOUD  = 24'h100000;
  localparam logic [DW-1:0] QUIET = 24'h000032;
  logic                     pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic                     req, run, rnd_on, chk_on;
  logic [PAW-1:0]           paddr;
  logic [31:0]              pwdata, prdata, q, v;
  logic [NPATH-1:0][DW-1:0] cur, x;
  logic [NPATH-1:0][DW-1:0] expq [$];
  logic [7:0]               lim [NPATH];
  olg_stream_t              in_stream, out_stream;
  integer                   seed, errors, checks_done, cyc, g, t;
  logic [13:0] ridx [8] = '{HPL_LIMIT_IDX, HPL_SRC_IDX, HPR_LIMIT_IDX, HPR_SRC_IDX,
                            SPK_LIMIT_IDX, SPK_SRC_IDX, GATE_CTRL_IDX, RAMP_CTRL_IDX};
  logic [31:0] rrst [8] = '{32'h81, 32'h1, 32'h81, 32'h2, 32'h81, 32'h40, 32'h0, 32'h0};
  logic [31:0] rmsk [8] = '{32'hFF, 32'h43, 32'hFF, 32'h43, 32'hFF, 32'h43, 32'h3F, 32'h77};
  logic [7:0]  codes [6] = '{8'h74, 8'h77, 8'h7A, 8'h7F, 8'h80, 8'h8C};
  int          hms [4] = '{30, 120, 250, 500};

  // Codes at 0 dB and above clip only the most negative 24-bit sample (800000h to -7FFFFFh), so they act as full scale.
  function automatic longint lmag(input logic [7:0] c);
    real f;
    if (c < 8'h74 || c >= 8'h80) return 64'h7FFFFF;
    f = 65536.0 * 10.0 ** ((real'(c) - 128.0) / 40.0);
    return (longint'(8388607) * longint'($rtoi(f + 0.5))) >>> 16;
  endfunction : lmag

  function automatic logic [NPATH-1:0][DW-1:0] clip3(input logic [NPATH-1:0][DW-1:0] d);
    longint s;
    longint m;
    for (int p = 0; p < NPATH; p++) begin
      s = $signed(d[p]);
      m = lmag(lim[p]);
      if (s > m) s = m;
      if (s < -m) s = -m;
      clip3[p] = s[DW-1:0];
    end
  endfunction : clip3

  function automatic integer thr(input integer c);
    return $rtoi(16777216.0 * 10.0 ** (-(60.0 + 6.0 * c) / 20.0) + 0.5);
  endfunction : thr

  function automatic logic [DW-1:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    return (r[31:30] == 2'h0) ? 24'h800000 : (r[31:30] == 2'h1) ? 24'h7FFFFF : r[23:0];
  endfunction : rnd

  task automatic stop_test();
    $display("checks_done %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [71:0] xp, input logic [71:0] sn);
    checks_done = checks_done + 1;
    if (sn !== xp) begin
      errors = errors + 1;
      $display("unexpected %s expected %h seen %h", n, xp, sn);
    end
  endtask : chk

  // The request stands until the rising edge at which pready is seen high; read data
  // and the error flag are taken at that same edge, and only then is the bus released.
  task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {i, 2'h0};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  olg_top #(.CYCLES_PER_MS(CPM)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_stream(in_stream), .out_stream(out_stream));
  olg_mixer_model u_mix (.pclk(pclk), .presetn(presetn), .req(req), .frame(cur),
                         .stream(in_stream));

  always #20 pclk = ~pclk;

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    req <= run & ~req;
    if (rnd_on && req) cur <= {rnd(), rnd(), rnd()};
    if (cyc == 20000) begin
      errors = errors + 1;
      $display("unexpected cycle count expected below 20000 seen 20000");
      stop_test();
    end
  end

  always @(posedge pclk) begin
    if (in_stream.valid === 1'b1) expq.push_back(clip3(in_stream.data));
    if (out_stream.valid === 1'b1) begin
      if (expq.size() == 0) begin
        errors = errors + 1;
        $display("unexpected out_stream.valid expected 0 seen 1");
      end else begin
        x = expq.pop_front();
        if (chk_on) chk("out_stream.data", x, out_stream.data);
      end
    end
  end

  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, req, run, rnd_on, chk_on} = 7'h01;
    {paddr, pwdata, cur} = '0;
    {errors, checks_done, cyc} = '0;
    seed = 32'h7B137805;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ridx[i], 32'h0);
      chk("reset value", 72'(rrst[i]), 72'(q));
      v = $random(seed);
      if (rmsk[i] == 32'hFF) v = 32'h74 + v % 25;
      apb(1'b1, ridx[i], v);
      apb(1'b0, ridx[i], 32'h0);
      chk("readback", 72'(v & rmsk[i]), 72'(q));
      apb(1'b1, ridx[i], rrst[i]);
    end
    apb(1'b1, 14'h0414, 32'hFFFF);
    chk("unmapped write", 72'h1, 72'(e));
    apb(1'b0, 14'h0414, 32'h0);
    chk("unmapped read", 72'h100000000, 72'({e, q}));
    $display("test registers done");
    rnd_on <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      run <= 1'b0;
      repeat (6) @(posedge pclk);
      for (int p = 0; p < NPATH; p++) begin
        lim[p] = (i == 6) ? 8'h80 : codes[(i + p) % 6];
        apb(1'b1, ridx[2 * p], 32'(lim[p]));
      end
      run <= (i < 6);
      repeat (40) @(posedge pclk);
    end
    rnd_on <= 1'b0;
    chk_on <= 1'b0;
    cur    <= {3{QUIET}};
    run    <= 1'b1;
    $display("test limiter done");
    for (int h = 0; h < 4; h++) begin
      apb(1'b1, GATE_CTRL_IDX, 32'(h * 16 + 1));
      cur <= {3{LOUD}};
      repeat (8) @(posedge pclk);
      cur <= {3{QUIET}};
      repeat (hms[h] * CPM - 10) @(posedge pclk);
      apb(1'b0, GATE_STAT_IDX, 32'h0);
      chk("gate before hold", 72'h0, 72'(q[2:0]));
      repeat (24) @(posedge pclk);
      apb(1'b0, GATE_STAT_IDX, 32'h0);
      chk("gate after hold", 72'h7, 72'(q[2:0]));
    end
    $display("test hold done");
    apb(1'b1, RAMP_CTRL_IDX, 32'h33);
    apb(1'b0, GATE_STAT_IDX, 32'h0);
    g = q[12:4];
    repeat (80) @(posedge pclk);
    apb(1'b0, GATE_STAT_IDX, 32'h0);
    chk("down steps", 72'h1, 72'((g - int'(q[12:4])) inside {[9:12]}));
    cur <= {QUIET, QUIET, LOUD};
    repeat (8) @(posedge pclk);
    apb(1'b0, GATE_STAT_IDX, 32'h0);
    chk("loud release", 72'h6, 72'(q[2:0]));
    g = q[12:4];
    repeat (80) @(posedge pclk);
    apb(1'b0, GATE_STAT_IDX, 32'h0);
    chk("up steps", 72'h1, 72'((int'(q[12:4]) - g) inside {[9:12]}));
    apb(1'b1, RAMP_CTRL_IDX, 32'h0);
    // Back to the shortest hold so the released path can close again within the wait.
    apb(1'b1, GATE_CTRL_IDX, 32'h1);
    cur <= {3{QUIET}};
    repeat (900) @(posedge pclk);
    apb(1'b0, GATE_STAT_IDX, 32'h0);
    chk("muted status", 72'h7, 72'(q));
    do begin
      @(negedge pclk);
    end while (out_stream.valid !== 1'b1);
    chk("muted output", 72'h0, out_stream.data);
    $display("test ramp done");
    for (int c = 0; c < 8; c++) begin
      t = thr(c);
      apb(1'b1, GATE_CTRL_IDX, 32'(c * 2 + 1));
      cur <= {24'((t + 1) / 2), QUIET, QUIET};
      repeat (8) @(posedge pclk);
      apb(1'b0, GATE_STAT_IDX, 32'h0);
      chk("at threshold", 72'h3, 72'(q[2:0]));
      cur <= {24'((t - 1) / 2), QUIET, QUIET};
      repeat (140) @(posedge pclk);
      apb(1'b0, GATE_STAT_IDX, 32'h0);
      chk("under threshold", 72'h7, 72'(q[2:0]));
    end
    $display("test threshold done");
    apb(1'b1, HPL_SRC_IDX, 32'h43);
    cur <= {LOUD, QUIET, QUIET};
    repeat (8) @(posedge pclk);
    apb(1'b0, GATE_STAT_IDX, 32'h0);
    chk("shared sources", 72'h2, 72'(q[2:0]));
    cur <= {3{QUIET}};
    repeat (140) @(posedge pclk);
    apb(1'b0, GATE_STAT_IDX, 32'h0);
    chk("all quiet", 72'h7, 72'(q[2:0]));
    apb(1'b1, GATE_CTRL_IDX, 32'h0);
    apb(1'b0, GATE_STAT_IDX, 32'h0);
    chk("gate disabled", 72'h0, 72'(q[2:0]));
    $display("test sources done");
    stop_test();
  end
endmodule : tb_output_path_limiter_noise_gate
`default_nettype wire
